// ---- inc/ussu_pkg.sv ----
// Purpose: Shared constants of the serial shift unit and its link partner
// Assumes: 50 MHz system clock on both ends
// Notes:   Register offsets are byte addresses on the Avalon-MM bus
package ussu_pkg;
   localparam int CLK_PERIOD_NS = 20;
   // Half period of the serial clock that the remote master makes
   localparam int LINK_HALF_NS = 80;
   localparam int LINK_HALF_CYC =
      (LINK_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   localparam logic [3:0] OFS_CTL = 4'h0;
   localparam logic [3:0] OFS_STS = 4'h4;
   localparam logic [3:0] OFS_DATA = 4'h8;
   localparam logic [3:0] OFS_PORT = 4'hc;

   // serial_control_reg fields
   localparam int CTL_TC = 0;
   localparam int CTL_STB = 1;
   localparam int CTL_CS_LO = 2;
   localparam int CTL_CS_HI = 3;
   localparam int CTL_WM0 = 4;
   localparam int CTL_WM1 = 5;
   localparam int CTL_OIE = 6;
   // serial_status_reg fields
   localparam int STS_CNT_LO = 0;
   localparam int STS_CNT_HI = 3;
   localparam int STS_OVF = 6;
   // Pin port register fields
   localparam int PORT_SDA_LATCH = 0;
   localparam int PORT_SDA_DIR = 1;
   localparam int PORT_CK_LATCH = 2;
   localparam int PORT_CK_DIR = 3;
   localparam int PORT_DO_DIR = 4;
   localparam int PORT_DO_LATCH = 5;

   localparam logic [7:0] CTL_RST = 8'h00;
   localparam logic [7:0] STS_RST = 8'h00;
   localparam logic [7:0] DATA_RST = 8'h00;
   localparam logic [7:0] PORT_RST = 8'h00;

   localparam logic [1:0] WM_OFF = 2'h0;
   localparam logic [1:0] WM_THREE = 2'h1;
   localparam logic [1:0] WM_TWO = 2'h2;
   localparam logic [1:0] WM_TWO_HOLD = 2'h3;

   localparam logic [1:0] CS_SW = 2'h0;
   localparam logic [1:0] CS_TMR = 2'h1;
endpackage

// ---- inc/ussu_link_if.sv ----
// Purpose: Serial link between the shift unit and its remote partner
// Assumes: Every pin line has a pull-up; drivers combine wired-AND
// Notes:   Device DO feeds partner DI and the other way round; SDA is
//          the shared DI line
`timescale 1ns/100ps
`default_nettype none
interface ussu_link_if;
   logic dev_ck_o;
   logic dev_ck_oe_n;
   logic dev_do_o;
   logic dev_do_oe_n;
   logic dev_di_o;
   logic dev_di_oe_n;
   logic part_ck_o;
   logic part_ck_oe_n;
   logic part_do_o;
   logic part_do_oe_n;
   logic part_di_o;
   logic part_di_oe_n;
   logic ck_line;
   logic dev_di_i;
   logic part_di_i;
   logic dev_ck_i;
   logic part_ck_i;

   assign ck_line = (dev_ck_oe_n | dev_ck_o) & (part_ck_oe_n | part_ck_o);
   assign dev_ck_i = ck_line;
   assign part_ck_i = ck_line;
   assign dev_di_i = (part_do_oe_n | part_do_o) & (part_di_oe_n | part_di_o)
      & (dev_di_oe_n | dev_di_o);
   assign part_di_i = (dev_do_oe_n | dev_do_o) & (dev_di_oe_n | dev_di_o)
      & (part_di_oe_n | part_di_o);

   modport dev (
      output dev_ck_o, dev_ck_oe_n, dev_do_o, dev_do_oe_n, dev_di_o,
      dev_di_oe_n,
      input dev_ck_i, dev_di_i
   );
   modport part (
      output part_ck_o, part_ck_oe_n, part_do_o, part_do_oe_n, part_di_o,
      part_di_oe_n,
      input part_ck_i, part_di_i
   );
endinterface
`default_nettype wire

// ---- hdl/ussu_sync2.sv ----
// Purpose: Two-flop synchroniser for pin inputs
// Assumes: Inputs are asynchronous levels
// Notes:   First stage feeds only the second stage
`timescale 1ns/100ps
`default_nettype none
module ussu_sync2 #(
   parameter int WIDTH = 2
) (
   input wire logic clk_i, // Sampling clock
   input wire logic rst_n_i, // Async reset, active low
   input wire logic [WIDTH-1:0] d_i, // Asynchronous levels
   output logic [WIDTH-1:0] q_o // Synchronised levels
);
   logic [WIDTH-1:0] meta_reg;
   logic [WIDTH-1:0] meta_next;
   logic [WIDTH-1:0] q_next;

   always_comb begin
      meta_next = d_i;
      q_next = meta_reg;
   end

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         meta_reg <= '1;
         q_o <= '1;
      end else begin
         meta_reg <= meta_next;
         q_o <= q_next;
      end
   end
endmodule
`default_nettype wire

// ---- hdl/ussu_partner.sv ----
// Purpose: Remote master shift unit driving the serial clock
// Assumes: Device end is slave; serial clock made by divider
// Notes:   Two-wire transfers are physical layer only, no start or ack
`timescale 1ns/100ps
`default_nettype none
module ussu_partner
   import ussu_pkg::*;
(
   input wire logic ref_clk_i, // System clock
   input wire logic rst_n_i, // Async reset, active low
   input wire logic start_i, // Start one byte transfer, pulse
   input wire logic [7:0] tx_byte_i, // Byte to send, MSB first
   input wire logic two_wire_i, // Open-drain two-wire link
   input wire logic mode1_i, // Data mode 1 (three-wire only)
   output logic [7:0] rx_byte_o, // Byte received
   output logic done_o, // Transfer complete, pulse
   output logic busy_o, // Transfer in progress
   ussu_link_if.part link // Serial pins
);
   typedef enum logic [4:0] {
      P_IDLE = 5'b00001,
      P_LOW = 5'b00010,
      P_RELW = 5'b00100,
      P_HIGH = 5'b01000,
      P_TAIL = 5'b10000
   } ussu_pstate_t;

   localparam logic [3:0] HALF_LAST = 4'(LINK_HALF_CYC - 1);

   ussu_pstate_t st_reg, st_next;
   logic [3:0] tmr_reg, tmr_next, bit_reg, bit_next;
   logic [7:0] sh_reg, sh_next, rx_next;
   logic two_reg, two_next, m1_reg, m1_next;
   logic done_next, busy_next;
   logic ck_o_next, ck_oe_n_next, do_o_next, do_oe_n_next, di_oe_n_next;
   logic [1:0] sync_q;
   logic [7:0] shifted;

   ussu_sync2 #(.WIDTH(2)) u_sync (
      .clk_i(ref_clk_i),
      .rst_n_i(rst_n_i),
      .d_i({link.part_ck_i, link.part_di_i}),
      .q_o(sync_q)
   );

   always_comb begin
      st_next = st_reg;
      tmr_next = tmr_reg;
      bit_next = bit_reg;
      sh_next = sh_reg;
      rx_next = rx_byte_o;
      two_next = two_reg;
      m1_next = m1_reg;
      done_next = 1'b0;
      busy_next = busy_o;
      ck_o_next = link.part_ck_o;
      ck_oe_n_next = link.part_ck_oe_n;
      do_o_next = link.part_do_o;
      do_oe_n_next = link.part_do_oe_n;
      di_oe_n_next = link.part_di_oe_n;
      shifted = {sh_reg[6:0], sync_q[0]};
      if (tmr_reg != 4'h0) begin
         tmr_next = tmr_reg - 4'h1;
      end
      case (st_reg)
         P_IDLE: begin
            // Three-wire clock idles driven low, so arming sees no edge
            if (!two_wire_i) begin
               ck_o_next = 1'b0;
               ck_oe_n_next = 1'b0;
            end
            if (start_i) begin
               // Data and drivers ready half a period before sampling
               sh_next = tx_byte_i;
               two_next = two_wire_i;
               m1_next = mode1_i & ~two_wire_i;
               bit_next = 4'h0;
               busy_next = 1'b1;
               ck_o_next = 1'b0;
               ck_oe_n_next = 1'b0;
               do_o_next = tx_byte_i[7];
               do_oe_n_next = two_wire_i;
               di_oe_n_next = ~two_wire_i | tx_byte_i[7];
               tmr_next = HALF_LAST;
               st_next = P_LOW;
            end
         end
         P_LOW: begin
            if (tmr_reg == 4'h0) begin
               if (m1_reg && bit_reg != 4'h0) begin
                  sh_next = shifted;
                  do_o_next = shifted[7];
               end
               if (two_reg) begin
                  ck_oe_n_next = 1'b1; // Release, line may be held
                  st_next = P_RELW;
               end else begin
                  ck_o_next = 1'b1;
                  tmr_next = HALF_LAST;
                  st_next = P_HIGH;
               end
            end
         end
         P_RELW: begin
            // Slave stretch: wait until the line really rose
            if (sync_q[1]) begin
               tmr_next = HALF_LAST;
               st_next = P_HIGH;
            end
         end
         P_HIGH: begin
            if (tmr_reg == 4'h0) begin
               ck_o_next = 1'b0;
               ck_oe_n_next = 1'b0;
               bit_next = bit_reg + 4'h1;
               tmr_next = HALF_LAST;
               if (!m1_reg) begin
                  sh_next = shifted;
                  do_o_next = shifted[7];
                  di_oe_n_next = ~two_reg | shifted[7];
               end
               if (bit_reg == 4'h7) begin
                  if (m1_reg) begin
                     st_next = P_TAIL;
                  end else begin
                     rx_next = shifted;
                     done_next = 1'b1;
                     busy_next = 1'b0;
                     do_oe_n_next = 1'b1;
                     di_oe_n_next = 1'b1;
                     st_next = P_IDLE;
                  end
               end else begin
                  st_next = P_LOW;
               end
            end
         end
         P_TAIL: begin
            if (tmr_reg == 4'h0) begin
               rx_next = shifted;
               done_next = 1'b1;
               busy_next = 1'b0;
               do_oe_n_next = 1'b1;
               di_oe_n_next = 1'b1;
               st_next = P_IDLE;
            end
         end
         default: st_next = P_IDLE;
      endcase
   end

   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         st_reg <= P_IDLE;
         tmr_reg <= 4'h0;
         bit_reg <= 4'h0;
         sh_reg <= 8'h00;
         rx_byte_o <= 8'h00;
         two_reg <= 1'b0;
         m1_reg <= 1'b0;
         done_o <= 1'b0;
         busy_o <= 1'b0;
         link.part_ck_o <= 1'b0;
         link.part_ck_oe_n <= 1'b1;
         link.part_do_o <= 1'b0;
         link.part_do_oe_n <= 1'b1;
         link.part_di_o <= 1'b0;
         link.part_di_oe_n <= 1'b1;
      end else begin
         st_reg <= st_next;
         tmr_reg <= tmr_next;
         bit_reg <= bit_next;
         sh_reg <= sh_next;
         rx_byte_o <= rx_next;
         two_reg <= two_next;
         m1_reg <= m1_next;
         done_o <= done_next;
         busy_o <= busy_next;
         link.part_ck_o <= ck_o_next;
         link.part_ck_oe_n <= ck_oe_n_next;
         link.part_do_o <= do_o_next;
         link.part_do_oe_n <= do_oe_n_next;
         link.part_di_o <= 1'b0;
         link.part_di_oe_n <= di_oe_n_next;
      end
   end
endmodule
`default_nettype wire

// ---- hdl/ussu_device.sv ----
// Purpose: Universal serial shift unit, 8-bit shifter and 4-bit counter
// Assumes: Software reaches it over Avalon-MM; pins pass a synchroniser
// Notes:   Start condition detector is not built
//
// Our own choices: the register addresses and register access over Avalon-MM.
`timescale 1ns/100ps
`default_nettype none
module ussu_device
   import ussu_pkg::*;
(
   input wire logic ref_clk_i, // System clock
   input wire logic rst_n_i, // Async reset, active low
   input wire logic [3:0] avs_address_i, // Byte address
   input wire logic avs_read_i, // Read request
   input wire logic avs_write_i, // Write request
   input wire logic [31:0] avs_writedata_i, // Write data
   output logic [31:0] avs_readdata_o, // Read data
   output logic avs_waitrequest_o, // Wait, active high
   input wire logic timer_ovf_i, // Timer overflow, pulse
   output logic ovf_wake_o, // Overflow with enable set
   ussu_link_if.dev link // Serial pins
);
   logic oie_reg, oie_next;
   logic [1:0] wm_reg, wm_next, cs_reg, cs_next;
   logic sel_reg, sel_next;
   logic [7:0] sh_reg, sh_next;
   logic [3:0] cnt_reg, cnt_next;
   logic ovf_reg, ovf_next;
   logic ck_latch_reg, ck_latch_next, ck_dir_reg, ck_dir_next;
   logic sda_latch_reg, sda_latch_next, sda_dir_reg, sda_dir_next;
   logic do_latch_reg, do_latch_next, do_dir_reg, do_dir_next;
   logic olat_reg, olat_next;
   logic di_prev_reg, di_prev_next, ck_prev_reg, ck_prev_next;
   logic wait_next, wake_next;
   logic [31:0] rdata_next;
   logic ck_o_next, ck_oe_n_next, do_o_next, do_oe_n_next;
   logic di_o_next, di_oe_n_next;

   logic [1:0] sync_q;
   logic ck_s, di_s, req, wr, wctl, wsts, wdat, wport;
   logic rise, fall, ext, samp, oedge, sw_clk, tc, shift_en, tick;
   logic outbit, hold;
   logic [7:0] wd, rd;

   ussu_sync2 #(.WIDTH(2)) u_sync (
      .clk_i(ref_clk_i),
      .rst_n_i(rst_n_i),
      .d_i({link.dev_ck_i, link.dev_di_i}),
      .q_o(sync_q)
   );

   always_comb begin
      ck_s = sync_q[1];
      di_s = sync_q[0];
      wd = avs_writedata_i[7:0];
      req = avs_read_i | avs_write_i;
      wr = avs_write_i & ~avs_waitrequest_o;
      wctl = wr & (avs_address_i == OFS_CTL);
      wsts = wr & (avs_address_i == OFS_STS);
      wdat = wr & (avs_address_i == OFS_DATA);
      wport = wr & (avs_address_i == OFS_PORT);
      rise = ck_s & ~ck_prev_reg;
      fall = ~ck_s & ck_prev_reg;
      ext = cs_reg[1];
      samp = cs_reg[0] ? fall : rise;
      oedge = cs_reg[0] ? rise : fall;
      // Strobe acts only when the written source field is zero
      sw_clk = (wctl & wd[CTL_STB] & (wd[CTL_CS_HI:CTL_CS_LO] == CS_SW))
         | ((cs_reg == CS_TMR) & timer_ovf_i);
      tc = wctl & wd[CTL_TC];
      shift_en = sw_clk | (ext & samp);
      // Counter: both edges, or the toggle strobe when selected
      tick = sw_clk | (ext & ~sel_reg & (rise | fall))
         | (tc & wd[CTL_CS_HI] & wd[CTL_STB]);
      // Latch opposite the sampling edge; transparent otherwise
      outbit = ext ? olat_reg : sh_reg[7];
      hold = (wm_reg == WM_TWO_HOLD) & ovf_reg;

      case (avs_address_i)
         OFS_CTL: rd = {1'b0, oie_reg, wm_reg, cs_reg, 2'b00};
         OFS_STS: rd = {1'b0, ovf_reg, 2'b00, cnt_reg};
         OFS_DATA: rd = sh_reg;
         OFS_PORT: rd = {2'b00, do_latch_reg, do_dir_reg, ck_dir_reg,
            ck_latch_reg, sda_dir_reg, sda_latch_reg};
         default: rd = 8'h00;
      endcase

      wait_next = ~(req & avs_waitrequest_o);
      rdata_next = avs_readdata_o;
      if (req & avs_waitrequest_o) begin
         rdata_next = {24'h000000, rd};
      end

      oie_next = oie_reg;
      wm_next = wm_reg;
      cs_next = cs_reg;
      sel_next = sel_reg;
      if (wctl) begin
         oie_next = wd[CTL_OIE];
         wm_next = wd[CTL_WM1:CTL_WM0];
         cs_next = wd[CTL_CS_HI:CTL_CS_LO];
         sel_next = wd[CTL_STB]; // Stored selector in external mode
      end

      ck_latch_next = ck_latch_reg;
      ck_dir_next = ck_dir_reg;
      sda_latch_next = sda_latch_reg;
      sda_dir_next = sda_dir_reg;
      do_latch_next = do_latch_reg;
      do_dir_next = do_dir_reg;
      if (wport) begin
         ck_latch_next = wd[PORT_CK_LATCH];
         ck_dir_next = wd[PORT_CK_DIR];
         sda_latch_next = wd[PORT_SDA_LATCH];
         sda_dir_next = wd[PORT_SDA_DIR];
         do_latch_next = wd[PORT_DO_LATCH];
         do_dir_next = wd[PORT_DO_DIR];
      end
      if (tc) begin
         ck_latch_next = ~ck_latch_reg; // Direction does not matter
      end

      sh_next = sh_reg;
      olat_next = olat_reg;
      if (wdat) begin
         sh_next = wd;
         olat_next = wd[7];
      end else if (shift_en) begin
         // Software and timer clocks take the previously sampled bit
         sh_next = {sh_reg[6:0], sw_clk ? di_prev_reg : di_s};
      end
      if (ext & oedge & ~wdat) begin
         olat_next = sh_reg[7];
      end

      cnt_next = cnt_reg;
      if (wsts) begin
         cnt_next = wd[STS_CNT_HI:STS_CNT_LO];
      end else if (tick) begin
         cnt_next = cnt_reg + 4'h1;
      end
      ovf_next = ovf_reg;
      if (wsts & wd[STS_OVF]) begin
         ovf_next = 1'b0;
      end
      // Set wins over a clear in the same cycle
      if (tick & (cnt_reg == 4'hf)) begin
         ovf_next = 1'b1;
      end
      wake_next = oie_reg & ovf_reg;

      di_prev_next = di_s;
      ck_prev_next = ck_s;

      // Pins act as plain port pins unless a wire mode claims them
      ck_o_next = ck_latch_reg;
      ck_oe_n_next = ~ck_dir_reg;
      do_o_next = do_latch_reg;
      do_oe_n_next = ~do_dir_reg;
      di_o_next = sda_latch_reg;
      di_oe_n_next = ~sda_dir_reg;
      case (wm_reg)
         WM_THREE: begin
            do_o_next = outbit;
         end
         WM_TWO, WM_TWO_HOLD: begin
            // Open drain, never drives high
            ck_o_next = 1'b0;
            ck_oe_n_next = ~(ck_dir_reg & (~ck_latch_reg | hold));
            do_oe_n_next = 1'b1;
            di_o_next = 1'b0;
            di_oe_n_next = ~(sda_dir_reg & (~outbit | ~sda_latch_reg));
         end
         default: begin
         end
      endcase
   end

   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         oie_reg <= CTL_RST[CTL_OIE];
         wm_reg <= CTL_RST[CTL_WM1:CTL_WM0];
         cs_reg <= CTL_RST[CTL_CS_HI:CTL_CS_LO];
         sel_reg <= CTL_RST[CTL_STB];
         sh_reg <= DATA_RST;
         cnt_reg <= STS_RST[STS_CNT_HI:STS_CNT_LO];
         ovf_reg <= STS_RST[STS_OVF];
         ck_latch_reg <= PORT_RST[PORT_CK_LATCH];
         ck_dir_reg <= PORT_RST[PORT_CK_DIR];
         sda_latch_reg <= PORT_RST[PORT_SDA_LATCH];
         sda_dir_reg <= PORT_RST[PORT_SDA_DIR];
         do_latch_reg <= PORT_RST[PORT_DO_LATCH];
         do_dir_reg <= PORT_RST[PORT_DO_DIR];
         olat_reg <= 1'b0;
         di_prev_reg <= 1'b1;
         ck_prev_reg <= 1'b1;
         avs_waitrequest_o <= 1'b1;
         avs_readdata_o <= 32'h00000000;
         ovf_wake_o <= 1'b0;
         link.dev_ck_o <= 1'b0;
         link.dev_ck_oe_n <= 1'b1;
         link.dev_do_o <= 1'b0;
         link.dev_do_oe_n <= 1'b1;
         link.dev_di_o <= 1'b0;
         link.dev_di_oe_n <= 1'b1;
      end else begin
         oie_reg <= oie_next;
         wm_reg <= wm_next;
         cs_reg <= cs_next;
         sel_reg <= sel_next;
         sh_reg <= sh_next;
         cnt_reg <= cnt_next;
         ovf_reg <= ovf_next;
         ck_latch_reg <= ck_latch_next;
         ck_dir_reg <= ck_dir_next;
         sda_latch_reg <= sda_latch_next;
         sda_dir_reg <= sda_dir_next;
         do_latch_reg <= do_latch_next;
         do_dir_reg <= do_dir_next;
         olat_reg <= olat_next;
         di_prev_reg <= di_prev_next;
         ck_prev_reg <= ck_prev_next;
         avs_waitrequest_o <= wait_next;
         avs_readdata_o <= rdata_next;
         ovf_wake_o <= wake_next;
         link.dev_ck_o <= ck_o_next;
         link.dev_ck_oe_n <= ck_oe_n_next;
         link.dev_do_o <= do_o_next;
         link.dev_do_oe_n <= do_oe_n_next;
         link.dev_di_o <= di_o_next;
         link.dev_di_oe_n <= di_oe_n_next;
      end
   end
endmodule
`default_nettype wire

// ---- bench/ussu_checker.sv ----
// Purpose: Link-side checks between the shift unit and its partner
// Assumes: Both ends are design code, one clock domain
// Notes:   Spacing figures follow from the 4-cycle half period
`timescale 1ns/100ps
`default_nettype none
module ussu_checker (
   input wire logic ref_clk_i, // System clock
   input wire logic rst_n_i, // Async reset, active low
   input wire logic ck_line, // Resolved clock line
   input wire logic dev_ck_o, // Device clock drive
   input wire logic dev_ck_oe_n, // Device clock enable, low
   input wire logic dev_do_o, // Device data out
   input wire logic dev_do_oe_n, // Device data enable, low
   input wire logic dev_di_oe_n, // Device SDA enable, low
   input wire logic part_ck_o, // Partner clock drive
   input wire logic part_ck_oe_n, // Partner clock enable, low
   input wire logic part_do_o, // Partner data out
   input wire logic part_do_oe_n, // Partner data enable, low
   input wire logic part_di_oe_n // Partner SDA enable, low
);
   default clocking cb @(posedge ref_clk_i);
   endclocking
   default disable iff (!rst_n_i);

   property p_released;
      $rose(rst_n_i) |-> dev_ck_oe_n && dev_do_oe_n && dev_di_oe_n
         && part_ck_oe_n && part_do_oe_n && part_di_oe_n;
   endproperty
   a_released: assert property (p_released)
      else $error("pin driven at reset release");
   // Pin edges pass a synchroniser, so short phases would be lost
   property p_ck_high_min;
      $rose(ck_line) |-> ck_line [*3];
   endproperty
   a_ck_high_min: assert property (p_ck_high_min)
      else $error("clock high phase too short");
   property p_ck_low_min;
      $fell(ck_line) |-> !ck_line [*3];
   endproperty
   a_ck_low_min: assert property (p_ck_low_min)
      else $error("clock low phase too short");
   property p_part_ck_spacing;
      $changed(part_ck_o) |=> $stable(part_ck_o) [*2];
   endproperty
   a_part_ck_spacing: assert property (p_part_ck_spacing)
      else $error("partner clock changed too soon");
   property p_part_ck_drive;
      $fell(part_ck_oe_n) |=> !part_ck_oe_n [*2];
   endproperty
   a_part_ck_drive: assert property (p_part_ck_drive)
      else $error("partner clock drive too short");
   property p_part_do_spacing;
      $changed(part_do_o) |=> $stable(part_do_o) [*3];
   endproperty
   a_part_do_spacing: assert property (p_part_do_spacing)
      else $error("partner data changed within half period");
   property p_dev_do_spacing;
      $changed(dev_do_o) |=> $stable(dev_do_o);
   endproperty
   a_dev_do_spacing: assert property (p_dev_do_spacing)
      else $error("device data out changed twice in a row");
   property p_dev_ck_spacing;
      $changed(dev_ck_o) |=> $stable(dev_ck_o);
   endproperty
   a_dev_ck_spacing: assert property (p_dev_ck_spacing)
      else $error("device clock latch changed twice in a row");
   property p_dev_sda_spacing;
      $changed(dev_di_oe_n) |=> $stable(dev_di_oe_n);
   endproperty
   a_dev_sda_spacing: assert property (p_dev_sda_spacing)
      else $error("device data drive changed twice in a row");

   c_ck_fall: cover property ($fell(ck_line));
   c_dev_do: cover property ($changed(dev_do_o));
   c_dev_ck: cover property ($changed(dev_ck_o));
endmodule
`default_nettype wire

// ---- bench/tb_universal_serial_shift_unit.sv ----
// Purpose: Self-checking bench, shift unit against the remote master
// Assumes: Both ends are design code joined by the link interface
// Notes:   Expected values come from the register map alone
`timescale 1ns/100ps
`default_nettype none
module tb_universal_serial_shift_unit;
   import ussu_pkg::*;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic [3:0] addr = 4'h0;
   logic rd = 1'b0;
   logic wr = 1'b0;
   logic [31:0] wdata = 32'h0;
   logic [31:0] rdata;
   logic wait_rq;
   logic tmr = 1'b0;
   logic wake;
   logic start = 1'b0;
   logic [7:0] tx = 8'h00;
   logic two_w = 1'b0;
   logic m1 = 1'b0;
   logic [7:0] rx;
   logic done;
   logic busy;
   int fails = 0;
   int tests_run = 0;

   ussu_link_if link ();
   ussu_device u_ussu_device (.ref_clk_i(clk), .rst_n_i(rst_n),
      .avs_address_i(addr), .avs_read_i(rd), .avs_write_i(wr),
      .avs_writedata_i(wdata), .avs_readdata_o(rdata),
      .avs_waitrequest_o(wait_rq), .timer_ovf_i(tmr), .ovf_wake_o(wake),
      .link(link));
   ussu_partner u_ussu_partner (.ref_clk_i(clk), .rst_n_i(rst_n),
      .start_i(start), .tx_byte_i(tx), .two_wire_i(two_w), .mode1_i(m1),
      .rx_byte_o(rx), .done_o(done), .busy_o(busy), .link(link));
   ussu_checker u_ussu_checker (.ref_clk_i(clk), .rst_n_i(rst_n),
      .ck_line(link.ck_line), .dev_ck_o(link.dev_ck_o),
      .dev_ck_oe_n(link.dev_ck_oe_n), .dev_do_o(link.dev_do_o),
      .dev_do_oe_n(link.dev_do_oe_n), .dev_di_oe_n(link.dev_di_oe_n),
      .part_ck_o(link.part_ck_o), .part_ck_oe_n(link.part_ck_oe_n),
      .part_do_o(link.part_do_o), .part_do_oe_n(link.part_do_oe_n),
      .part_di_oe_n(link.part_di_oe_n));

   always #(CLK_PERIOD_NS / 2) clk = ~clk;

   task automatic end_of_test();
      $display("checks %0d mismatches %0d", tests_run, fails);
      if (fails == 0 && tests_run > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         $display("[FAIL] %0t got %h exp %h", $time, got, exp);
         fails++;
      end
   endtask

   // Request held until waitrequest is sampled low
   task automatic bus(input logic w, input logic [3:0] a,
         input logic [7:0] d, output logic [31:0] q);
      int n;
      n = 0;
      @(posedge clk);
      addr <= a;
      wr <= w;
      rd <= !w;
      wdata <= {24'h0, d};
      @(posedge clk);
      while (wait_rq !== 1'b0 && n < 50) begin
         @(posedge clk);
         n++;
      end
      q = rdata;
      if (n == 50) fails++;
      wr <= 1'b0;
      rd <= 1'b0;
   endtask

   task automatic w8(input logic [3:0] a, input logic [7:0] d);
      logic [31:0] q;
      bus(1'b1, a, d, q);
   endtask

   task automatic r8(input logic [3:0] a, input logic [7:0] e);
      logic [31:0] q;
      bus(1'b0, a, 8'h00, q);
      chk(q, {24'h0, e});
   endtask

   function automatic logic [7:0] cw(input logic [1:0] wm,
         input logic [1:0] cs, input logic [1:0] st);
      return {2'b00, wm, cs, st};
   endfunction

   task automatic xfer(input logic [7:0] b, input logic tw, input logic md);
      int n;
      n = 0;
      @(posedge clk);
      start <= 1'b1;
      tx <= b;
      two_w <= tw;
      m1 <= md;
      @(posedge clk);
      start <= 1'b0;
      @(posedge clk);
      chk({31'h0, busy}, 32'h1);
      while (done !== 1'b1 && n < 500) begin
         @(posedge clk);
         n++;
      end
      if (n == 500) fails++;
      // Device sees the last edge 2-3 cycles late
      repeat (4) @(posedge clk);
   endtask

   task automatic t_reset();
      r8(OFS_CTL, CTL_RST);
      r8(OFS_STS, STS_RST);
      r8(OFS_DATA, DATA_RST);
      r8(OFS_PORT, PORT_RST);
      w8(4'h2, 8'hff);
      r8(4'h2, 8'h00);
      $display("test reset done");
   endtask

   task automatic t_strobe();
      w8(OFS_DATA, 8'h35);
      w8(OFS_STS, 8'h40);
      w8(OFS_CTL, cw(WM_THREE, CS_SW, 2'b00));
      r8(OFS_DATA, 8'h35);
      w8(OFS_CTL, cw(WM_THREE, CS_SW, 2'b10));
      r8(OFS_DATA, 8'h6b);
      r8(OFS_CTL, 8'h10);
      r8(OFS_STS, 8'h01);
      for (int i = 0; i < 15; i++) w8(OFS_CTL, cw(WM_THREE, CS_SW, 2'b10));
      r8(OFS_STS, 8'h40);
      r8(OFS_DATA, 8'hff);
      chk({31'h0, wake}, 32'h0);
      w8(OFS_CTL, 8'h50);
      repeat (2) @(posedge clk);
      chk({31'h0, wake}, 32'h1);
      w8(OFS_STS, 8'h40);
      repeat (2) @(posedge clk);
      chk({31'h0, wake}, 32'h0);
      $display("test strobe done");
   endtask

   task automatic t_timer();
      w8(OFS_STS, 8'h00);
      w8(OFS_CTL, cw(WM_THREE, CS_TMR, 2'b00));
      repeat (3) begin
         @(posedge clk);
         tmr <= 1'b1;
         @(posedge clk);
         tmr <= 1'b0;
      end
      r8(OFS_STS, 8'h03);
      $display("test timer done");
   endtask

   task automatic t_toggle();
      w8(OFS_STS, 8'h00);
      repeat (3) w8(OFS_CTL, cw(WM_THREE, 2'b10, 2'b11));
      r8(OFS_PORT, 8'h04);
      r8(OFS_STS, 8'h03);
      r8(OFS_CTL, 8'h18);
      w8(OFS_CTL, cw(WM_THREE, 2'b10, 2'b01));
      r8(OFS_STS, 8'h03);
      r8(OFS_PORT, 8'h00);
      $display("test toggle done");
   endtask

   task automatic t_spi(input logic m);
      w8(OFS_PORT, 8'h10);
      w8(OFS_DATA, m ? 8'h5a : 8'ha5);
      w8(OFS_STS, 8'h40);
      w8(OFS_CTL, cw(WM_THREE, {1'b1, m}, 2'b00));
      xfer(m ? 8'hc3 : 8'h3c, 1'b0, m);
      chk({24'h0, rx}, m ? 32'h5a : 32'ha5);
      r8(OFS_DATA, m ? 8'hc3 : 8'h3c);
      r8(OFS_STS, 8'h40);
      $display("test spi mode %0d done", m);
   endtask

   task automatic t_two();
      w8(OFS_PORT, 8'h03);
      w8(OFS_DATA, 8'h96);
      w8(OFS_STS, 8'h40);
      w8(OFS_CTL, cw(WM_TWO, 2'b10, 2'b00));
      repeat (3) @(posedge clk);
      chk({31'h0, link.part_di_i}, 32'h1);
      w8(OFS_PORT, 8'h02);
      repeat (3) @(posedge clk);
      chk({31'h0, link.part_di_i}, 32'h0);
      w8(OFS_PORT, 8'h03);
      xfer(8'hff, 1'b1, 1'b0);
      chk({24'h0, rx}, 32'h96);
      r8(OFS_DATA, 8'h96);
      r8(OFS_STS, 8'h40);
      $display("test two-wire done");
   endtask

   task automatic t_hold();
      // Reset frees the clock line the two-wire master holds low
      @(posedge clk);
      rst_n <= 1'b0;
      repeat (2) @(posedge clk);
      rst_n <= 1'b1;
      w8(OFS_PORT, 8'h0c);
      w8(OFS_STS, 8'h4f);
      w8(OFS_CTL, cw(WM_TWO_HOLD, CS_SW, 2'b10));
      repeat (3) @(posedge clk);
      chk({31'h0, link.ck_line}, 32'h0);
      r8(OFS_STS, 8'h40);
      w8(OFS_STS, 8'h40);
      repeat (3) @(posedge clk);
      chk({31'h0, link.ck_line}, 32'h1);
      $display("test hold done");
   endtask

   initial begin
      repeat (20) @(posedge clk);
      rst_n <= 1'b1;
      t_reset();
      t_strobe();
      t_timer();
      t_toggle();
      t_spi(1'b0);
      t_spi(1'b1);
      t_two();
      t_hold();
      end_of_test();
   end

   // Tests need well under 5000 cycles
   initial begin
      #200000;
      fails++;
      end_of_test();
   end
endmodule
`default_nettype wire
